// file: hdl/dacr_ctrl.sv
// axi4-lite register block steering a 32-step dac reference
`timescale 1ns/1ps
`include "dacr_defs.svh"
module dacr_ctrl (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic [3:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [3:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output dacr_pkg::dacr_ana_t   anaCtrl,
  output logic                  pinOverride
);
  import dacr_pkg::*;

  // =====================================================================
  // registers
  logic [7:0]  cfg_r;
  logic [4:0]  level_r;
  logic        configured_r;
  logic        awHeld_r;
  logic        wHeld_r;
  logic [3:0]  awAddr_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;

  // =====================================================================
  // write path: address and data caught separately, in any order
  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;

  logic        doWrite;
  logic [3:0]  wrAddr;
  logic [31:0] wrData;
  logic        wrLane0;
  assign doWrite = (awHeld_r || s_axi_awvalid) && (wHeld_r || s_axi_wvalid) && !s_axi_bvalid;
  assign wrAddr  = awHeld_r ? awAddr_r : s_axi_awaddr;
  assign wrData  = wHeld_r ? wData_r : s_axi_wdata;
  assign wrLane0 = wHeld_r ? wStrb_r[0] : s_axi_wstrb[0];

  function automatic logic isMapped(input logic [3:0] a);
    isMapped = (a == `DACR_CFG_OFFS) || (a == `DACR_LEVEL_OFFS) || (a == `DACR_STATUS_OFFS);
  endfunction

  always_ff @(posedge ref_clk) begin
    if (srst || doWrite) begin
      awHeld_r <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_r <= 1'b1;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      awAddr_r <= s_axi_awaddr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || doWrite) begin
      wHeld_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_r <= 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DACR_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= isMapped(wrAddr) ? `DACR_RESP_OKAY : `DACR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // =====================================================================
  // configuration register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg_r        <= `DACR_CFG_RST;
      configured_r <= 1'b0;
    end else if (doWrite && wrLane0 && wrAddr == `DACR_CFG_OFFS) begin
      cfg_r        <= wrData[7:0] & `DACR_CFG_MASK;
      configured_r <= 1'b1;
    end
  end

  // =====================================================================
  // level register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      level_r <= `DACR_LEVEL_RST;
    end else if (doWrite && wrLane0 && wrAddr == `DACR_LEVEL_OFFS && configured_r) begin
      level_r <= wrData[4:0];
    end
  end

  // =====================================================================
  // analogue controls; the ladder itself gives code/32 of the span, so 31 tops out below upper
  // enable bit
  assign anaCtrl.enable      = cfg_r[`DACR_CFG_EN_BIT];
  assign anaCtrl.pinDrive    = cfg_r[`DACR_CFG_PIN_BIT];
  assign anaCtrl.upperSel    = dacr_upsel_t'(cfg_r[`DACR_CFG_UP_HI:`DACR_CFG_UP_LO]);
  assign anaCtrl.lowerExtNeg = cfg_r[`DACR_CFG_LO_BIT];
  // step of span/32, top code 31
  assign anaCtrl.level       = level_r;
  assign pinOverride         = cfg_r[`DACR_CFG_PIN_BIT] && cfg_r[`DACR_CFG_EN_BIT];

  // =====================================================================
  // read path, one cycle after address taken
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `DACR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= isMapped(s_axi_araddr) ? `DACR_RESP_OKAY : `DACR_RESP_SLVERR;
      unique case (s_axi_araddr)
        `DACR_CFG_OFFS:    s_axi_rdata <= {24'h00_0000, cfg_r};
        `DACR_LEVEL_OFFS:  s_axi_rdata <= {27'h000_0000, level_r};
        `DACR_STATUS_OFFS: s_axi_rdata <= {30'h0000_0000, pinOverride, configured_r};
        default:           s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // dacr_ctrl

// file: hdl/dacr_defs.svh
// register offsets, field positions, reset values for the dac reference control
// =====================================================================
// What this block does
// - once the configuration register has been written, the level register accepts a code from 0 to 31, giving 32 output steps.
// - each step of the level code raises the output by 1/32 of the span between lower and upper reference.
// - the top code gives 31/32 of the upper reference, never the full upper reference.
// - the applied level code reads back like a converted input value.
// - configuration bit 7 enables the converter when 1 and disables it when 0.
// - configuration bit 5 set, with bit 7 also set, drives the external pin with the output, overriding its normal function.
// - configuration bits 3..2 pick the upper reference: 00 supply, 01 external positive pin, 10 fixed reference, 11 unused.
// - configuration bit 0 picks the lower reference: 0 ground, 1 external negative pin.
`ifndef DACR_DEFS_SVH
`define DACR_DEFS_SVH
// =====================================================================
// register map (byte addresses)
`define DACR_CFG_OFFS    4'h0
`define DACR_LEVEL_OFFS  4'h4
`define DACR_STATUS_OFFS 4'h8
// =====================================================================
// configuration fields
`define DACR_CFG_EN_BIT   7
`define DACR_CFG_PIN_BIT  5
`define DACR_CFG_UP_HI    3
`define DACR_CFG_UP_LO    2
`define DACR_CFG_LO_BIT   0
`define DACR_CFG_MASK     8'hAD
`define DACR_CFG_RST      8'h00
`define DACR_LEVEL_RST    5'h00
// =====================================================================
// bus answers
`define DACR_RESP_OKAY   2'h0
`define DACR_RESP_SLVERR 2'h2
`endif

// file: hdl/dacr_pkg.sv
// types for the dac reference control
package dacr_pkg;
  // =====================================================================
  // upper reference choice
  typedef enum logic [1:0] {
    DACR_UP_SUPPLY = 2'b00,
    DACR_UP_EXTPOS = 2'b01,
    DACR_UP_FIXED  = 2'b10,
    DACR_UP_UNUSED = 2'b11
  } dacr_upsel_t;
  // =====================================================================
  // analogue side controls
  typedef struct packed {
    logic        enable;
    logic        pinDrive;
    dacr_upsel_t upperSel;
    logic        lowerExtNeg;
    logic [4:0]  level;
  } dacr_ana_t;
endpackage

// file: tb/dacr_ctrl_checker.sv
// bus and output assertions for the dac reference control
`timescale 1ns/1ps
module dacr_ctrl_checker
  import dacr_pkg::*;
(
  input wire logic                ref_clk,
  input wire logic                srst,
  input wire logic [3:0]          s_axi_awaddr,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic [31:0]         s_axi_wdata,
  input wire logic [3:0]          s_axi_wstrb,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  input wire logic [3:0]          s_axi_araddr,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic [1:0]          s_axi_rresp,
  input wire logic                s_axi_rvalid,
  input wire dacr_pkg::dacr_ana_t anaCtrl,
  input wire logic                pinOverride
);
  // =====================================================================
  // handshakes
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_rd; s_axi_arvalid && s_axi_arready; endsequence
  property p_cfg;
    logic [31:0] d;
    (s_wr ##0 (s_axi_awaddr == 4'h0 && s_axi_wstrb[0]), d = s_axi_wdata) |=> anaCtrl[9:5] == {d[7], d[5], d[3:2], d[0]};
  endproperty
  // =====================================================================
  // checks
  a_pin_drive: assert property (pinOverride == (anaCtrl.enable && anaCtrl.pinDrive))
    else $error("pin override does not follow enable and pin drive");
  a_cfg_apply: assert property (p_cfg)
    else $error("configuration fields not applied");
  a_reset_clear: assert property ($past(srst) |-> anaCtrl == '0 && !pinOverride)
    else $error("outputs not cleared by reset");
  a_write_answer: assert property (s_wr |=> s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_rd |=> s_axi_rvalid)
    else $error("read data late");
  a_level_read: assert property (s_rd ##0 s_axi_araddr == 4'h4 |=> s_axi_rdata == {27'h0, $past(anaCtrl[4:0])})
    else $error("level read back wrong");
  a_level_cause: assert property ($changed(anaCtrl.level) |-> $past(s_axi_awaddr == 4'h4 && s_axi_wready))
    else $error("level changed without a level write");
  a_unmapped_err: assert property (s_rd ##0 s_axi_araddr == 4'hC |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule // dacr_ctrl_checker

// file: tb/testbench.sv
// self-checking bench for the dac reference control
`timescale 1ns/1ps
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin failures++; $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module testbench;
  import dacr_pkg::*;
  logic        ref_clk, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pinOverride;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [33:0] expQ[$], e;
  dacr_ana_t   anaCtrl;
  int          failures = 0, checksDone = 0;
  dacr_ctrl dut (.*);
  initial begin
    ref_clk = 0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // =====================================================================
  // bus tasks: handshakes sampled at the rising edge, released right after it
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic b = 0;
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    while (!b) begin
      @(posedge ref_clk);
      b = s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
    `CHK(s_axi_bresp, ((a == 4'hC) ? 2'h2 : 2'h0))
  endtask
  task automatic rd(input logic [3:0] a, input logic [33:0] x);
    logic t = 0;
    expQ.push_back(x);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    while (!t) begin @(posedge ref_clk); t = s_axi_arready; end
    s_axi_arvalid <= 0;
    t = 0;
    while (!t) begin @(posedge ref_clk); t = s_axi_rvalid; end
    s_axi_rready <= 0;
  endtask
  // =====================================================================
  // result watcher against the expectation queue
  always @(posedge ref_clk) if (s_axi_rvalid && s_axi_rready) begin
    e = expQ.pop_front();
    `CHK({s_axi_rresp, s_axi_rdata}, e)
  end
  task summarize;
    if (failures == 0 && checksDone > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, far beyond the few dozen cycles the run needs
  initial begin #50000; failures++; summarize(); end
  initial begin
    srst = 1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    void'($urandom(53));
    repeat (4) @(posedge ref_clk);
    srst <= 0;
    rd(4'h0, 34'h0);
    wr(4'h4, 32'h5, 4'hF);
    rd(4'h4, 34'h0);
    for (int i = 0; i < 4; i++) begin
      v = $urandom; v[7] = i[0]; v[3:2] = i[1:0];
      wr(4'h0, v, 4'hF);
      rd(4'h0, {26'h0, v[7:0] & 8'hAD});
    end
    for (int j = 0; j < 3; j++) begin
      v = (j == 0) ? 32'h0 : (j == 1) ? 32'hFFFF_FFFF : $urandom;
      wr(4'h4, v, 4'hF);
      rd(4'h4, {29'h0, v[4:0]});
    end
    wr(4'hC, 32'h1, 4'hF);
    rd(4'hC, {2'h2, 32'h0});
    summarize();
  end
endmodule // testbench
bind dacr_ctrl dacr_ctrl_checker chk (.*);
